// ==== msh_pkg.sv ====
// Package of the motion setpoint handshake: parameter addresses, reset
// values, legal ranges, status and control bit positions, mode codes.
// Assumes one system clock; addresses are the fieldbus parameter numbers.
package msh_pkg;

    // ------------------------------------------------------------
    // Parameter addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_RAMP_ACCELERATION = 16'h0614;
    localparam logic [15:0] ADDR_RAMP_DECELERATION = 16'h0616;
    localparam logic [15:0] ADDR_JERK_FILTER_TIME  = 16'h061a;
    localparam logic [15:0] ADDR_TARGET_POSITION   = 16'h1b1c;
    localparam logic [15:0] ADDR_TARGET_SPEED      = 16'h1b1e;
    localparam logic [15:0] ADDR_CONTROL_WORD      = 16'h1b00;
    localparam logic [15:0] ADDR_STATUS_WORD       = 16'h1b04;

    // ------------------------------------------------------------
    // Reset values and legal ranges
    // ------------------------------------------------------------
    localparam logic [31:0] RST_RAMP_ACCELERATION = 32'h0000_0258;
    localparam logic [31:0] RST_RAMP_DECELERATION = 32'h0000_02ee;
    localparam logic [15:0] RST_JERK_FILTER_TIME  = 16'h0000;
    localparam logic [31:0] RST_TARGET_POSITION   = 32'h0000_0000;
    localparam logic [31:0] RST_TARGET_SPEED      = 32'h0000_003c;
    localparam logic [15:0] RST_CONTROL_WORD      = 16'h0000;
    localparam logic [31:0] ACC_MIN               = 32'h0000_0001;
    localparam logic [31:0] DEC_MIN               = 32'h0000_00c8;
    localparam logic [31:0] RAMP_MAX              = 32'h002d_c6c0;
    localparam logic [31:0] SPEED_MIN             = 32'h0000_0001;

    // ------------------------------------------------------------
    // Control and status bit positions
    // ------------------------------------------------------------
    localparam int CW_NEW_SETPOINT = 4;
    localparam int CW_IMMEDIATE    = 5;
    localparam int CW_RELATIVE     = 6;
    localparam int SW_TARGET       = 10;
    localparam int SW_ACK          = 12;
    localparam int SW_ERROR        = 13;
    localparam int SW_END          = 14;
    localparam int SW_REF_OK       = 15;

    // ------------------------------------------------------------
    // Operating mode codes on the mode input
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_NONE     = 3'h0;
    localparam logic [2:0] MODE_PROF_POS = 3'h1;
    localparam logic [2:0] MODE_PROF_VEL = 3'h3;
    localparam logic [2:0] MODE_HOMING   = 3'h6;
    localparam logic [2:0] MODE_JOG      = 3'h7;

    // Setpoint set handed over as one unit
    typedef struct packed {
        logic [31:0] position;
        logic [31:0] speed;
        logic [31:0] accel;
        logic [31:0] decel;
        logic        relative;
    } msh_set_t;

endpackage

// ==== msh_sp_if.sv ====
// Interface between the parameter front end and the setpoint engine.
// Assumes both ends run on sys_clk.
interface msh_sp_if;
    import msh_pkg::*;
    logic     edge_p;
    logic     immediate;
    logic     cw_new_level;
    msh_set_t incoming;
    msh_set_t applied;
    logic     start_p;
    logic     moving;
    logic     pending;
    logic     ack;
    logic     reached;

    modport front (
        output edge_p, immediate, cw_new_level, incoming,
        input  applied, start_p, moving, pending, ack, reached
    );
    modport engine (
        input  edge_p, immediate, cw_new_level, incoming,
        output applied, start_p, moving, pending, ack, reached
    );
endinterface

// ==== msh_setpoint.sv ====
// Setpoint engine: takes new position sets at once or buffers them
// until arrival, and keeps the acknowledge and target-reached flags.
// Assumes the trajectory reports arrival, halt and fault on sys_clk.
module msh_setpoint
    import msh_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  nrst,
    input  wire logic  traj_arrived,
    input  wire logic  halt_req,
    input  wire logic  fault_active,
    msh_sp_if.engine   sp
);

    msh_set_t buf_q;
    msh_set_t app_q;
    logic     start_q;
    logic     moving_q;
    logic     pending_q;
    logic     ack_q;
    logic     reached_q;
    logic     stop;

    assign stop = halt_req | fault_active;

    // ------------------------------------------------------------
    // Set takeover
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            buf_q     <= '0;
            app_q     <= '0;
            start_q   <= 1'b0;
            moving_q  <= 1'b0;
            pending_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (stop) begin
                moving_q  <= 1'b0;
                pending_q <= 1'b0;
            end else if (sp.edge_p) begin
                if (!moving_q || sp.immediate) begin
                    app_q    <= sp.incoming;
                    start_q  <= 1'b1;
                    moving_q <= 1'b1;
                end else begin
                    buf_q     <= sp.incoming;
                    pending_q <= 1'b1;
                end
            end else if (moving_q && traj_arrived) begin
                if (pending_q) begin
                    app_q     <= buf_q;
                    start_q   <= 1'b1;
                    pending_q <= 1'b0;
                end else begin
                    moving_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Acknowledge and target reached
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else if (sp.edge_p && !stop) begin
            ack_q <= 1'b1;
        end else if (!sp.cw_new_level && !pending_q) begin
            ack_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reached_q <= 1'b0;
        end else if (stop || start_q) begin
            reached_q <= 1'b0;
        end else if (moving_q && traj_arrived && !pending_q && !sp.edge_p) begin
            reached_q <= 1'b1;
        end
    end

    assign sp.applied = app_q;
    assign sp.start_p = start_q;
    assign sp.moving  = moving_q;
    assign sp.pending = pending_q;
    assign sp.ack     = ack_q;
    assign sp.reached = reached_q;

endmodule // msh_setpoint

// ==== msh_top.sv ====
// Command and status logic of the motor drive: ramp settings, jerk
// filter, jog end detection and the profile-position handshake.
// Assumes a same-clock parameter port from the fieldbus side and
// trajectory feedback on sys_clk; jog pins are asynchronous.
//
// Notes on behaviour
// - Acceleration 32 bit, 1..3000000, default 600
// - Deceleration 32 bit, 200..3000000, default 750
// - Jerk time only 0 or 1..128 powers
// - Jerk filter used in four motion modes
// - Jerk change refused unless mode finished
// - Jog: bits 10 and 12 meaningless
// - Jog: bit 14 when done and still
// - Jog ends at standstill, no direction
// - Halt or error also ends jog
// - Jog requests each on own input
// - Control bit 6 picks absolute or relative
// - Only rising bit 4 starts a move
// - Bit 5 read only on that edge
// - Buffer set during move, apply on arrival
// - Newer set overwrites buffered one
// - Bit 5 set applies values at once
// - Bit 10 only when target reached
// - Bit 12 acknowledges; master waits for zero
// - Bit 13 error, bit 15 reference valid
// - Bit 14 when positioning done and still
// - Halt or fault leaves bit 10 low
module msh_top
    import msh_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] param_addr,
    input  wire logic [31:0] param_wdata,
    input  wire logic        param_wr,
    input  wire logic        param_rd,
    output logic      [31:0] param_rdata,
    output logic             param_ack,
    output logic             param_err,
    input  wire logic [2:0]  op_mode,
    input  wire logic        motor_standstill,
    input  wire logic        traj_arrived,
    input  wire logic        halt_req,
    input  wire logic        fault_active,
    input  wire logic        ref_valid,
    input  wire logic        jog_pos_pin,
    input  wire logic        jog_neg_pin,
    input  wire logic        jog_fast_pin,
    output logic      [31:0] move_position,
    output logic      [31:0] move_speed,
    output logic      [31:0] move_accel,
    output logic      [31:0] move_decel,
    output logic             move_relative,
    output logic             move_start,
    output logic      [15:0] jerk_time_out,
    output logic             jog_run_pos,
    output logic             jog_run_neg,
    output logic             jog_fast,
    output logic      [15:0] status_word
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [31:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic jerk_legal(input logic [31:0] v);
        logic ok;
        ok = 1'b0;
        if (v[31:8] == 24'h000000) begin
            ok = (v[7:0] & (v[7:0] - 8'h01)) == 8'h00;
        end
        jerk_legal = ok;
    endfunction

    function automatic logic is_motion_mode(input logic [2:0] m);
        is_motion_mode = (m == MODE_PROF_POS) || (m == MODE_PROF_VEL) ||
                         (m == MODE_HOMING) || (m == MODE_JOG);
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] acc_q;
    logic [31:0] dec_q;
    logic [15:0] jerk_q;
    logic [31:0] tpos_q;
    logic [31:0] tspd_q;
    logic [15:0] cw_q;
    logic [15:0] status_q;
    logic [31:0] rdata_q;
    logic        ack_q;
    logic        err_q;
    logic [15:0] jerk_out_q;
    logic [2:0]  jog_s1_q;
    logic [2:0]  jog_s2_q;
    logic        jog_req_prev_q;
    logic        jog_active_q;
    logic        jog_pos_q;
    logic        jog_neg_q;
    logic        jog_fast_q;
    logic        sel_acc;
    logic        sel_dec;
    logic        sel_jerk;
    logic        sel_tpos;
    logic        sel_tspd;
    logic        sel_cw;
    logic        sel_sw;
    logic        wr_ok;
    logic        mode_end;
    logic        jog_req;
    logic        jog_one_dir;
    msh_set_t    incoming;

    msh_sp_if sp ();

    assign sel_acc  = param_addr == ADDR_RAMP_ACCELERATION;
    assign sel_dec  = param_addr == ADDR_RAMP_DECELERATION;
    assign sel_jerk = param_addr == ADDR_JERK_FILTER_TIME;
    assign sel_tpos = param_addr == ADDR_TARGET_POSITION;
    assign sel_tspd = param_addr == ADDR_TARGET_SPEED;
    assign sel_cw   = param_addr == ADDR_CONTROL_WORD;
    assign sel_sw   = param_addr == ADDR_STATUS_WORD;
    assign mode_end = status_q[SW_END];

    // ------------------------------------------------------------
    // Write acceptance
    // ------------------------------------------------------------
    always_comb begin
        wr_ok = 1'b0;
        if (sel_acc) begin
            wr_ok = in_range(param_wdata, ACC_MIN, RAMP_MAX);
        end else if (sel_dec) begin
            wr_ok = in_range(param_wdata, DEC_MIN, RAMP_MAX);
        end else if (sel_jerk) begin
            wr_ok = jerk_legal(param_wdata) && mode_end;
        end else if (sel_tpos || sel_cw) begin
            wr_ok = 1'b1;
        end else if (sel_tspd) begin
            wr_ok = param_wdata >= SPEED_MIN;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q  <= RST_RAMP_ACCELERATION;
            dec_q  <= RST_RAMP_DECELERATION;
            jerk_q <= RST_JERK_FILTER_TIME;
            tpos_q <= RST_TARGET_POSITION;
            tspd_q <= RST_TARGET_SPEED;
            cw_q   <= RST_CONTROL_WORD;
        end else if (param_wr && wr_ok) begin
            if (sel_acc) begin
                acc_q <= param_wdata;
            end
            if (sel_dec) begin
                dec_q <= param_wdata;
            end
            if (sel_jerk) begin
                jerk_q <= param_wdata[15:0];
            end
            if (sel_tpos) begin
                tpos_q <= param_wdata;
            end
            if (sel_tspd) begin
                tspd_q <= param_wdata;
            end
            if (sel_cw) begin
                cw_q <= param_wdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Setpoint edge and hand-over
    // ------------------------------------------------------------
    // Values written in the same cycle as the edge are not yet stored,
    // so position, speed and ramps come from the registers as they stand, the relative bit from the written word.
    always_comb begin
        incoming          = '0;
        incoming.position = tpos_q;
        incoming.speed    = tspd_q;
        incoming.accel    = acc_q;
        incoming.decel    = dec_q;
        incoming.relative = param_wdata[CW_RELATIVE];
    end

    assign sp.edge_p       = param_wr && sel_cw && (op_mode == MODE_PROF_POS) &&
                             param_wdata[CW_NEW_SETPOINT] && !cw_q[CW_NEW_SETPOINT];
    assign sp.immediate    = param_wdata[CW_IMMEDIATE];
    assign sp.cw_new_level = cw_q[CW_NEW_SETPOINT];
    assign sp.incoming     = incoming;

    msh_setpoint u_setpoint (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .traj_arrived (traj_arrived),
        .halt_req     (halt_req),
        .fault_active (fault_active),
        .sp           (sp.engine)
    );

    assign move_position = sp.applied.position;
    assign move_speed    = sp.applied.speed;
    assign move_accel    = sp.applied.accel;
    assign move_decel    = sp.applied.decel;
    assign move_relative = sp.applied.relative;
    assign move_start    = sp.start_p;

    // ------------------------------------------------------------
    // Jog inputs and jog end
    // ------------------------------------------------------------
    // one pin per request
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jog_s1_q <= 3'h0;
            jog_s2_q <= 3'h0;
        end else begin
            jog_s1_q <= {jog_fast_pin, jog_neg_pin, jog_pos_pin};
            jog_s2_q <= jog_s1_q;
        end
    end

    // Both directions at once means no motion
    assign jog_req     = jog_s2_q[0] | jog_s2_q[1];
    assign jog_one_dir = jog_s2_q[0] ^ jog_s2_q[1];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jog_active_q   <= 1'b0;
            jog_req_prev_q <= 1'b0;
        end else begin
            jog_req_prev_q <= jog_req;
            if (op_mode != MODE_JOG || halt_req || fault_active) begin
                jog_active_q <= 1'b0;
            end else if (jog_one_dir && !jog_req_prev_q) begin
                jog_active_q <= 1'b1;
            end else if (motor_standstill && !jog_req) begin
                jog_active_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jog_pos_q  <= 1'b0;
            jog_neg_q  <= 1'b0;
            jog_fast_q <= 1'b0;
        end else begin
            jog_pos_q  <= jog_active_q && jog_one_dir && jog_s2_q[0];
            jog_neg_q  <= jog_active_q && jog_one_dir && jog_s2_q[1];
            jog_fast_q <= jog_s2_q[2];
        end
    end

    // ------------------------------------------------------------
    // Jerk filter output
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jerk_out_q <= 16'h0000;
        end else begin
            jerk_out_q <= is_motion_mode(op_mode) ? jerk_q : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= 16'h0000;
        end else begin
            status_q <= 16'h0000;
            status_q[SW_ERROR]  <= fault_active;
            status_q[SW_REF_OK] <= ref_valid;
            if (op_mode == MODE_PROF_POS) begin
                status_q[SW_TARGET] <= sp.reached;
                status_q[SW_ACK]    <= sp.ack;
                status_q[SW_END]    <= !sp.moving && motor_standstill;
            end else if (op_mode == MODE_JOG) begin
                // bits 10 and 12 held low
                status_q[SW_END] <= !jog_active_q && motor_standstill;
            end else begin
                status_q[SW_END] <= motor_standstill;
            end
        end
    end

    // ------------------------------------------------------------
    // Parameter port answer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ack_q <= param_wr | param_rd;
            err_q <= 1'b0;
            if (param_wr) begin
                // Status is read-only; unmapped or illegal writes are refused
                err_q <= !wr_ok;
            end else if (param_rd) begin
                unique case (1'b1)
                    sel_acc:  rdata_q <= acc_q;
                    sel_dec:  rdata_q <= dec_q;
                    sel_jerk: rdata_q <= {16'h0000, jerk_q};
                    sel_tpos: rdata_q <= tpos_q;
                    sel_tspd: rdata_q <= tspd_q;
                    sel_cw:   rdata_q <= {16'h0000, cw_q};
                    sel_sw:   rdata_q <= {16'h0000, status_q};
                    default: begin
                        rdata_q <= 32'h0000_0000;
                        err_q   <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign param_rdata   = rdata_q;
    assign param_ack     = ack_q;
    assign param_err     = err_q;
    assign jerk_time_out = jerk_out_q;
    assign jog_run_pos   = jog_pos_q;
    assign jog_run_neg   = jog_neg_q;
    assign jog_fast      = jog_fast_q;
    assign status_word   = status_q;

endmodule // msh_top

// ==== msh_top_chk.sv ====
// Checker of the drive command port and status word timing.
// Assumes it is bound to msh_top and sees only its ports.
module msh_top_chk
    import msh_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [15:0] param_addr,
    input wire logic [31:0] param_wdata,
    input wire logic        param_wr,
    input wire logic        param_rd,
    input wire logic        param_ack,
    input wire logic        param_err,
    input wire logic [2:0]  op_mode,
    input wire logic        halt_req,
    input wire logic        fault_active,
    input wire logic        ref_valid,
    input wire logic [15:0] status_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Parameter port and status timing
    // ------------------------------------------------------------
    a_ack_follows_req: assert property ((param_wr || param_rd) |=> param_ack) else $error("no answer");
    a_err_with_ack: assert property (param_err |-> param_ack) else $error("err without ack");
    a_acc_range: assert property (param_wr && param_addr == ADDR_RAMP_ACCELERATION &&
        (param_wdata < ACC_MIN || param_wdata > RAMP_MAX) |=> param_err) else $error("acc taken");
    a_dec_range: assert property (param_wr && param_addr == ADDR_RAMP_DECELERATION &&
        (param_wdata < DEC_MIN || param_wdata > RAMP_MAX) |=> param_err) else $error("dec taken");
    a_jerk_locked: assert property (param_wr && param_addr == ADDR_JERK_FILTER_TIME &&
        !status_word[SW_END] |=> param_err) else $error("jerk taken");
    a_halt_no_reach: assert property ((halt_req || fault_active) [*2] |=>
        !status_word[SW_TARGET]) else $error("reached during halt");
    a_error_flag: assert property (1'b1 |=> status_word[SW_ERROR] == $past(fault_active))
        else $error("error flag wrong");
    a_ref_flag: assert property (1'b1 |=> status_word[SW_REF_OK] == $past(ref_valid))
        else $error("reference flag wrong");
    a_jog_bits_zero: assert property (op_mode == MODE_JOG ##1 op_mode == MODE_JOG |=>
        !status_word[SW_TARGET] && !status_word[SW_ACK]) else $error("jog bits set");
endmodule // msh_top_chk

// ==== msh_master.sv ====
// Fieldbus master model: one parameter access at a time.
// Assumes the drive answers one cycle after each strobe.
module msh_master (
    input  wire logic        sys_clk,
    output logic      [15:0] param_addr,
    output logic      [31:0] param_wdata,
    output logic             param_wr,
    output logic             param_rd,
    input  wire logic [31:0] param_rdata,
    input  wire logic        param_ack,
    input  wire logic        param_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [32:0] ans;
    logic        ack_seen;
    initial begin
        param_addr = 16'h0000;
        param_wdata = 32'h0000_0000;
        param_wr = 1'b0;
        param_rd = 1'b0;
    end
    // One strobe, answer taken, then next
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        param_addr = a;
        param_wdata = d;
        param_wr = wr;
        param_rd = !wr;
        @(negedge sys_clk);
        ack_seen = param_ack;
        ans = {param_err, param_rdata};
        param_wr = 1'b0;
        param_rd = 1'b0;
        // Released bus shows the inverse
        param_addr = ~a;
        param_wdata = ~d;
    endtask
endmodule // msh_master

// ==== tb.sv ====
// Self-checking bench of msh_top with a fieldbus master model.
// Assumes one 250 MHz clock; inputs change at the falling edge.
module tb
    import msh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, nrst = 1'b0, param_wr, param_rd, param_ack, param_err, move_relative, move_start;
    logic st = 1'b1, arr = 1'b0, halt = 1'b0, flt = 1'b0, refv = 1'b0, jp = 1'b0, jn = 1'b0, jf = 1'b0;
    logic jog_run_pos, jog_run_neg, jog_fast;
    logic [2:0] op_mode = MODE_NONE;
    logic [15:0] param_addr, jerk_time_out, status_word;
    logic [31:0] param_wdata, param_rdata, move_position, move_speed, move_accel, move_decel, v, acc, dec, jerk, p2;
    int fail_count = 0, n_checks = 0, cycles = 0, seed = 82690;
    msh_top i_msh_top (.sys_clk, .nrst, .param_addr, .param_wdata, .param_wr, .param_rd, .param_rdata,
        .param_ack, .param_err, .op_mode, .motor_standstill(st), .traj_arrived(arr), .halt_req(halt),
        .fault_active(flt), .ref_valid(refv), .jog_pos_pin(jp), .jog_neg_pin(jn), .jog_fast_pin(jf),
        .move_position, .move_speed, .move_accel, .move_decel, .move_relative, .move_start, .jerk_time_out,
        .jog_run_pos, .jog_run_neg, .jog_fast, .status_word);
    msh_master u_master (.sys_clk, .param_addr, .param_wdata, .param_wr, .param_rd, .param_rdata, .param_ack,
        .param_err);
    always #2 sys_clk = ~sys_clk;
    // Ceiling far above the run's length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    task automatic results();
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [79:0] seen, input logic [79:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic acc_rw(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [32:0] exp);
        u_master.xfer(wr, a, d);
        chk("ack", u_master.ack_seen, 1'b1);
        chk("answer", wr ? {u_master.ans[32], 32'h0} : u_master.ans, exp);
    endtask
    task automatic ramp(input logic [15:0] a, input logic [31:0] lo, inout logic [31:0] m);
        acc_rw(1'b1, a, v, {v < lo || v > RAMP_MAX, 32'h0});
        if (v >= lo && v <= RAMP_MAX) m = v;
        acc_rw(1'b0, a, 32'h0, {1'b0, m});
    endtask
    task automatic arrive();
        @(negedge sys_clk) arr = 1'b1;
        @(negedge sys_clk) arr = 1'b0;
    endtask
    initial begin
        acc = RST_RAMP_ACCELERATION;
        dec = RST_RAMP_DECELERATION;
        jerk = 32'h0;
        repeat (20) @(negedge sys_clk);
        nrst = 1'b1;
        acc_rw(1'b0, ADDR_TARGET_SPEED, 32'h0, 33'h0_0000_003c);
        acc_rw(1'b0, ADDR_TARGET_POSITION, 32'h0, 33'h0);
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hc7 : (i == 2) ? 32'h1 : (i == 3) ? RAMP_MAX
                : (i == 4) ? RAMP_MAX + 32'h1 : $unsigned($random(seed)) % 32'd3000010;
            ramp(ADDR_RAMP_ACCELERATION, ACC_MIN, acc);
            ramp(ADDR_RAMP_DECELERATION, DEC_MIN, dec);
        end
        // Only off or powers of two up to 128
        for (int i = 0; i < 130; i++) begin
            v = i;
            acc_rw(1'b1, ADDR_JERK_FILTER_TIME, v, {!($countones(v) < 2 && v <= 128), 32'h0});
            if ($countones(v) < 2 && v <= 128) jerk = v;
        end
        st = 1'b0;
        acc_rw(1'b1, ADDR_JERK_FILTER_TIME, 32'h0, 33'h1_0000_0000);
        acc_rw(1'b0, ADDR_JERK_FILTER_TIME, 32'h0, {1'b0, jerk});
        st = 1'b1;
        acc_rw(1'b1, ADDR_STATUS_WORD, 32'h0, 33'h1_0000_0000);
        acc_rw(1'b0, 16'h0002, 32'h0, 33'h1_0000_0000);
        op_mode = MODE_HOMING;
        refv = 1'b1;
        repeat (4) @(negedge sys_clk);
        op_mode = MODE_PROF_POS;
        v = $random(seed);
        acc_rw(1'b1, ADDR_TARGET_POSITION, v, 33'h0);
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h10, 33'h0);
        chk("start", {move_start, move_position, move_relative}, {1'b1, v, 1'b0});
        chk("ramps", {jerk_time_out, move_accel, move_decel}, {jerk[15:0], acc, dec});
        @(negedge sys_clk);
        chk("ack bit", status_word[SW_ACK], 1'b1);
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h10, 33'h0);
        chk("level start", move_start, 1'b0);
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h0, 33'h0);
        p2 = $random(seed);
        acc_rw(1'b1, ADDR_TARGET_POSITION, p2, 33'h0);
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h10, 33'h0);
        chk("buffered start", move_start, 1'b0);
        arrive();
        chk("takeover", {move_start, move_speed, move_position}, {1'b1, RST_TARGET_SPEED, p2});
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h0, 33'h0);
        v = $random(seed);
        acc_rw(1'b1, ADDR_TARGET_POSITION, v, 33'h0);
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h70, 33'h0);
        chk("immediate", {move_start, move_position, move_relative}, {1'b1, v, 1'b1});
        arrive();
        @(negedge sys_clk);
        chk("reached", {status_word[SW_TARGET], status_word[SW_END]}, 2'b11);
        @(negedge sys_clk) halt = 1'b1;
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h0, 33'h0);
        acc_rw(1'b1, ADDR_CONTROL_WORD, 32'h10, 33'h0);
        chk("halted", {move_start, status_word[SW_TARGET], status_word[SW_END]}, 3'b001);
        halt = 1'b0;
        flt = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("error", {status_word[SW_ERROR], status_word[SW_REF_OK]}, 2'b11);
        flt = 1'b0;
        op_mode = MODE_JOG;
        jp = 1'b1;
        jf = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk("jog run", {jog_run_pos, jog_fast}, 2'b11);
        jp = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("jog end", {jog_run_pos, status_word[SW_END], status_word[SW_TARGET]}, 3'b010);
        jn = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk("jog neg", jog_run_neg, 1'b1);
        halt = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("jog halt", jog_run_neg, 1'b0);
        results();
    end
endmodule // tb
bind msh_top msh_top_chk u_chk (.sys_clk, .nrst, .param_addr, .param_wdata, .param_wr, .param_rd, .param_ack,
    .param_err, .op_mode, .halt_req, .fault_active, .ref_valid, .status_word);
